/* File: hdl/nvw_pkg.sv */
// package for the data nonvolatile write controller: offsets, fields, timing
// Notes on behaviour
// - write needs 55h, AAh, then trigger set
// - wrong cycle count in sequence refuses store
// - write trigger sets only with enable gate
// - hardware clears write enable gate only on power-up or reset
// - clearing enable does not abort write
// - completion clears trigger, sets complete flag
// - complete flag stays until software clears
// - enable gate cleared at power-up
// - no array write during 64 ms power-up timer
// - protect bit zero still allows cpu access
// - unlock register has no storage, reads zero
// - address latch selects one of 256 bytes
// - read trigger loads data latch next cycle
// - triggers set-only by software, hardware clears
// - pin/watchdog reset mid-write sets error, clears latches
package nvw_pkg;
  localparam logic [11:0] OFF_DATA    = 12'h000;
  localparam logic [11:0] OFF_ADDR    = 12'h004;
  localparam logic [11:0] OFF_CTRL    = 12'h008;
  localparam logic [11:0] OFF_KEY     = 12'h00c;
  localparam logic [11:0] OFF_FLAGS   = 12'h010;
  localparam logic [11:0] OFF_ENABLES = 12'h014;
  localparam logic [11:0] OFF_GLOBAL  = 12'h018;
  localparam int CTL_RD    = 0;
  localparam int CTL_WR    = 1;
  localparam int CTL_WRITE_ENABLE_GATE  = 2;
  localparam int CTL_WRITE_ERROR_FLAG = 3;
  localparam int FLG_DONE  = 7;
  localparam int ENA_DONE  = 7;
  localparam int GLB_GIE   = 7;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam int CLK_MHZ        = 100;
  localparam int PWRUP_MS       = 64;
  localparam int PWRUP_CYCLES   = PWRUP_MS * 1000 * CLK_MHZ;
  localparam int WRITE_CYCLES   = 4000;
  typedef enum logic [1:0] {NVW_SEQ_IDLE, NVW_SEQ_KEY1, NVW_SEQ_KEY2} nvw_seq_t;
endpackage : nvw_pkg

/* File: hdl/nvw_array.sv */
// 256-byte nonvolatile array model with registered read data
`timescale 1ns/1ps
`default_nettype none
module nvw_array #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule : nvw_array
`default_nettype wire

/* File: hdl/nvw_ctrl.sv */
// data nonvolatile write control with apb register access
`timescale 1ns/1ps
`default_nettype none
module nvw_ctrl import nvw_pkg::*; #(
  parameter int PWRUP_CNT = PWRUP_CYCLES,
  parameter int WRITE_CNT = WRITE_CYCLES,
  parameter int AW        = 8
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_por,
  input  wire logic        i_pin_wdt_rst,
  input  wire logic        i_data_protect_config,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_write_busy,
  output logic             o_write_complete_flag,
  output logic             o_pwrup_active
);
  logic [AW-1:0] nv_address_latch_q;
  logic [7:0]    nv_data_latch_q;
  logic          write_enable_gate_q;
  logic          write_error_flag_q;
  logic          wr_q;
  logic          rd_q;
  logic          rd_load_q;
  logic          write_complete_flag_q;
  logic          write_complete_irq_enable_q;
  logic          global_irq_enable_q;
  nvw_seq_t      seq_q;
  logic [31:0]   pwrup_cnt_q;
  logic [31:0]   wr_cnt_q;
  logic          arr_we;
  logic [7:0]    arr_rdata;
  logic          acc;
  logic          wr_acc;
  logic          wr_start;
  logic          wr_done;
  logic          mapped;
  logic          pwrup_busy;
  logic [7:0]    ctrl_read;

  // single-cycle answer; reads and writes land in the access phase
  assign acc    = i_psel && i_penable;
  assign wr_acc = acc && i_pwrite;
  assign mapped = (i_paddr == OFF_DATA) || (i_paddr == OFF_ADDR) ||
                  (i_paddr == OFF_CTRL) || (i_paddr == OFF_KEY) ||
                  (i_paddr == OFF_FLAGS) || (i_paddr == OFF_ENABLES) ||
                  (i_paddr == OFF_GLOBAL);
  assign pwrup_busy = (pwrup_cnt_q != 32'h0);

  // power-up timer: counting holds off every array write
  always_ff @(posedge i_sys_clk) begin
    if (i_por) begin
      pwrup_cnt_q <= 32'(PWRUP_CNT);
    end else if (pwrup_busy) begin
      pwrup_cnt_q <= pwrup_cnt_q - 32'h1;
    end
  end

  // key detector: every access phase advances or drops the sequence
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_por) begin
      seq_q <= NVW_SEQ_IDLE;
    end else if (acc) begin
      case (seq_q)
        NVW_SEQ_IDLE: begin
          seq_q <= (wr_acc && i_paddr == OFF_KEY && i_pwdata[7:0] == KEY_FIRST)
                   ? NVW_SEQ_KEY1 : NVW_SEQ_IDLE;
        end
        NVW_SEQ_KEY1: begin
          // second key must be the very next access
          seq_q <= (wr_acc && i_paddr == OFF_KEY && i_pwdata[7:0] == KEY_SECOND)
                   ? NVW_SEQ_KEY2 : NVW_SEQ_IDLE;
        end
        NVW_SEQ_KEY2: begin
          seq_q <= NVW_SEQ_IDLE;
        end
        default: begin
          seq_q <= NVW_SEQ_IDLE;
        end
      endcase
    end
  end

  // trigger counts only as the access right after both keys
  // data_protect_config gates only external programmer, never the cpu
  assign wr_start = wr_acc && i_paddr == OFF_CTRL && i_pwdata[CTL_WR] &&
                    seq_q == NVW_SEQ_KEY2 && write_enable_gate_q &&
                    !wr_q && !pwrup_busy;
  assign wr_done  = wr_q && (wr_cnt_q == 32'h1);
  assign arr_we   = wr_done;

  // self-timed write; enable gate is not looked at once running
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_por) begin
      wr_q     <= 1'b0;
      wr_cnt_q <= 32'h0;
    end else if (wr_start) begin
      wr_q     <= 1'b1;
      wr_cnt_q <= 32'(WRITE_CNT);
    end else if (wr_q) begin
      wr_cnt_q <= wr_cnt_q - 32'h1;
      if (wr_done) begin
        wr_q <= 1'b0;
      end
    end
  end

  // enable gate: software writes only, cleared on power-up and on reset
  always_ff @(posedge i_sys_clk) begin
    if (i_por) begin
      write_enable_gate_q <= 1'b0;
    end else if (!i_rst_n) begin
      write_enable_gate_q <= 1'b0;
    end else if (wr_acc && i_paddr == OFF_CTRL) begin
      write_enable_gate_q <= i_pwdata[CTL_WRITE_ENABLE_GATE];
    end
  end

  // error flag survives the pin/watchdog reset that aborts a write
  always_ff @(posedge i_sys_clk) begin
    if (i_por) begin
      write_error_flag_q <= 1'b0;
    end else if (i_pin_wdt_rst && wr_q) begin
      write_error_flag_q <= 1'b1;
    end else if (!i_rst_n) begin
      write_error_flag_q <= write_error_flag_q;
    end else if (wr_acc && i_paddr == OFF_CTRL) begin
      write_error_flag_q <= i_pwdata[CTL_WRITE_ERROR_FLAG];
    end
  end

  // read trigger: array answers next cycle, then data latch loads
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_por) begin
      rd_q      <= 1'b0;
      rd_load_q <= 1'b0;
    end else begin
      rd_q      <= wr_acc && i_paddr == OFF_CTRL && i_pwdata[CTL_RD] && !wr_q;
      rd_load_q <= rd_q;
    end
  end

  // latches; frozen while a write runs, but a read trigger in the access that starts the write reloads the data latch
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_por) begin
      nv_address_latch_q <= AW'(0);
      nv_data_latch_q    <= RST_BYTE;
    end else begin
      if (wr_acc && i_paddr == OFF_ADDR && !wr_q) begin
        nv_address_latch_q <= i_pwdata[AW-1:0];
      end
      if (rd_q) begin
        nv_data_latch_q <= arr_rdata;
      end else if (wr_acc && i_paddr == OFF_DATA && !wr_q) begin
        nv_data_latch_q <= i_pwdata[7:0];
      end
    end
  end

  // completion flag: set wins over a same-cycle software clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_por) begin
      write_complete_flag_q <= 1'b0;
    end else if (wr_done) begin
      write_complete_flag_q <= 1'b1;
    end else if (wr_acc && i_paddr == OFF_FLAGS) begin
      write_complete_flag_q <= i_pwdata[FLG_DONE];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_por) begin
      write_complete_irq_enable_q <= 1'b0;
      global_irq_enable_q         <= 1'b0;
    end else if (wr_acc && i_paddr == OFF_ENABLES) begin
      write_complete_irq_enable_q <= i_pwdata[ENA_DONE];
    end else if (wr_acc && i_paddr == OFF_GLOBAL) begin
      global_irq_enable_q <= i_pwdata[GLB_GIE];
    end
  end

  always_comb begin
    ctrl_read            = 8'h00;
    ctrl_read[CTL_RD]    = rd_q;
    ctrl_read[CTL_WR]    = wr_q;
    ctrl_read[CTL_WRITE_ENABLE_GATE]  = write_enable_gate_q;
    ctrl_read[CTL_WRITE_ERROR_FLAG] = write_error_flag_q;
  end

  // apb answer; key register reads zero, unmapped gives slverr
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_prdata  <= 32'h0;
      if (i_psel && !i_penable && !i_pwrite) begin
        case (i_paddr)
          OFF_DATA:    o_prdata <= {24'h0, nv_data_latch_q};
          OFF_ADDR:    o_prdata <= {{(32-AW){1'b0}}, nv_address_latch_q};
          OFF_CTRL:    o_prdata <= {24'h0, ctrl_read};
          OFF_FLAGS:   o_prdata <= {24'h0, write_complete_flag_q, 7'h00};
          OFF_ENABLES: o_prdata <= {24'h0, write_complete_irq_enable_q, 7'h00};
          OFF_GLOBAL:  o_prdata <= {24'h0, global_irq_enable_q, 7'h00};
          default:     o_prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_write_busy          <= 1'b0;
      o_write_complete_flag <= 1'b0;
      o_pwrup_active        <= 1'b0;
    end else begin
      o_write_busy          <= wr_q;
      o_write_complete_flag <= write_complete_flag_q;
      o_pwrup_active        <= pwrup_busy;
    end
  end

  nvw_array #(
    .AW (AW),
    .DW (8)
  ) u_array (
    .i_sys_clk (i_sys_clk),
    .i_we      (arr_we),
    .i_addr    (nv_address_latch_q),
    .i_wdata   (nv_data_latch_q),
    .o_rdata   (arr_rdata)
  );

  logic unused;
  assign unused = i_data_protect_config | rd_load_q;
endmodule : nvw_ctrl
`default_nettype wire

/* File: verif/nvw_ctrl_assertions.sv */
// port-level checker for the nonvolatile write controller
`timescale 1ns/1ps
`default_nettype none
module nvw_ctrl_assertions import nvw_pkg::*; #(
  parameter int WRITE_CNT = WRITE_CYCLES
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_write_busy,
  input wire logic        o_write_complete_flag,
  input wire logic        o_pwrup_active
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] busy_len_q;
  wire setup = i_psel && !i_penable;
  wire bad_addr = (i_paddr > OFF_GLOBAL) || (i_paddr[1:0] != 2'h0);
  wire flag_clr = i_psel && i_penable && i_pwrite && (i_paddr == OFF_FLAGS);
  // length of the current busy run, checked when it ends
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) busy_len_q <= 16'h0;
    else if (o_write_busy) busy_len_q <= busy_len_q + 16'h1;
    else busy_len_q <= 16'h0;
  end
  sequence s_setup;
    setup;
  endsequence
  sequence s_answer;
    ##1 o_pready;
  endsequence
  property p_ready;
    s_setup |-> s_answer;
  endproperty
  property p_unmapped;
    setup && bad_addr |=> o_pready && o_pslverr;
  endproperty
  property p_key_zero;
    setup && !i_pwrite && i_paddr == OFF_KEY |=> o_prdata == 32'h0;
  endproperty
  property p_upper_zero;
    setup && !i_pwrite |=> o_prdata[31:8] == 24'h0;
  endproperty
  property p_busy_len;
    // a reset that aborts a write also drops busy; only a normal finish counts
    $fell(o_write_busy) && $past(i_rst_n) |-> busy_len_q == 16'(WRITE_CNT);
  endproperty
  property p_done_flag;
    $fell(o_write_busy) && $past(i_rst_n) |-> ##[0:1] o_write_complete_flag;
  endproperty
  property p_flag_hold;
    o_write_complete_flag && !flag_clr && !$past(flag_clr) |=> o_write_complete_flag;
  endproperty
  property p_pwrup;
    $rose(o_write_busy) |-> !o_pwrup_active;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not flagged");
  a_key_zero: assert property (p_key_zero) else $error("key register not zero");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_busy_len: assert property (p_busy_len) else $error("write length wrong");
  a_done_flag: assert property (p_done_flag) else $error("no completion flag");
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared alone");
  a_pwrup: assert property (p_pwrup) else $error("write in power-up");
endmodule : nvw_ctrl_assertions
bind nvw_ctrl nvw_ctrl_assertions #(.WRITE_CNT(WRITE_CNT)) nvw_ctrl_assertions_inst (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_write_busy(o_write_busy),
  .o_write_complete_flag(o_write_complete_flag), .o_pwrup_active(o_pwrup_active));
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the nonvolatile write controller
`timescale 1ns/1ps
`default_nettype none
module testbench import nvw_pkg::*; ;
  localparam int PW = 60;
  localparam int WC = 10;
  logic        clk = 1'b0;
  logic        rst_n, por, pin_rst, prot, psel, penable, pwrite, pready, pslverr;
  logic        busy, done, pwrup, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int          failures = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  nvw_ctrl #(.PWRUP_CNT(PW), .WRITE_CNT(WC)) nvw_ctrl_inst (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_por(por), .i_pin_wdt_rst(pin_rst),
    .i_data_protect_config(prot), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_write_busy(busy), .o_write_complete_flag(done),
    .o_pwrup_active(pwrup));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask : rdchk
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, OFF_ADDR, a);
    acc(1'b1, OFF_DATA, d);
    acc(1'b1, OFF_CTRL, 8'h04);
  endtask : put
  // optional read between keys breaks the sequence on purpose
  task automatic seq(input logic [7:0] k1, input logic [7:0] k2, input logic gap,
                     input logic [7:0] ctl);
    acc(1'b1, OFF_KEY, k1);
    if (gap) acc(1'b0, OFF_DATA, 8'h00);
    acc(1'b1, OFF_KEY, k2);
    acc(1'b1, OFF_CTRL, ctl);
    repeat (2) @(posedge clk);
  endtask : seq
  task automatic wait_idle();
    while (busy !== 1'b0) @(posedge clk);
  endtask : wait_idle
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, pin_rst, psel, penable, pwrite, paddr, pwdata} = '0;
    por = 1'b1;
    prot = 1'b1;
    repeat (6) @(posedge clk);
    por <= 1'b0;
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rdchk(12'(4 * i), 32'h0);
    rdchk(12'h01c, 32'h0);
    chk({31'h0, err}, 32'h1);
    put(8'h10, 8'h5a);
    seq(KEY_FIRST, KEY_SECOND, 1'b0, 8'h06);
    chk({30'h0, pwrup, busy}, 32'h2);
    while (pwrup !== 1'b0) @(posedge clk);
    seq(KEY_SECOND, KEY_FIRST, 1'b0, 8'h06);
    chk({31'h0, busy}, 32'h0);
    seq(KEY_FIRST, KEY_SECOND, 1'b1, 8'h06);
    chk({31'h0, busy}, 32'h0);
    acc(1'b1, OFF_CTRL, 8'h00);
    seq(KEY_FIRST, KEY_SECOND, 1'b0, 8'h02);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_FLAGS, 32'h0);
    acc(1'b1, OFF_ENABLES, 8'h80);
    acc(1'b1, OFF_GLOBAL, 8'h80);
    rdchk(OFF_ENABLES, 32'h80);
    rdchk(OFF_GLOBAL, 32'h80);
    acc(1'b1, OFF_GLOBAL, 8'h00);
    rdchk(OFF_GLOBAL, 32'h0);
    prot <= 1'b0;
    put(8'hff, 8'ha5);
    seq(KEY_FIRST, KEY_SECOND, 1'b0, 8'h06);
    chk({31'h0, busy}, 32'h1);
    acc(1'b1, OFF_CTRL, 8'h00);
    acc(1'b1, OFF_ADDR, 8'h33);
    chk({31'h0, busy}, 32'h1);
    wait_idle();
    chk({31'h0, done}, 32'h1);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_FLAGS, 32'h80);
    rdchk(OFF_ADDR, 32'hff);
    repeat (20) @(posedge clk);
    rdchk(OFF_FLAGS, 32'h80);
    acc(1'b1, OFF_FLAGS, 8'h00);
    rdchk(OFF_FLAGS, 32'h0);
    chk({31'h0, done}, 32'h0);
    put(8'h00, 8'h3c);
    seq(KEY_FIRST, KEY_SECOND, 1'b0, 8'h06);
    wait_idle();
    rdchk(OFF_CTRL, 32'h04);
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, OFF_DATA, 8'h00);
      acc(1'b1, OFF_ADDR, i ? 8'h00 : 8'hff);
      acc(1'b1, OFF_CTRL, 8'h01);
      rdchk(OFF_DATA, i ? 32'h3c : 32'ha5);
      rdchk(OFF_CTRL, 32'h0);
    end
    put(8'h20, 8'h77);
    seq(KEY_FIRST, KEY_SECOND, 1'b0, 8'h06);
    rst_n <= 1'b0;
    pin_rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    pin_rst <= 1'b0;
    acc(1'b0, OFF_CTRL, 8'h00);
    chk({31'h0, rdata[CTL_WRITE_ERROR_FLAG]}, 32'h1);
    rdchk(OFF_ADDR, 32'h0);
    rdchk(OFF_DATA, 32'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
